//--- shared/irq_accept_pkg.sv
// constants for the dual-mode interrupt acceptance block
package irq_accept_pkg;
	localparam int          N_SRC        = 8;
	localparam int          PRIO_W       = 3;
	// sources 4..7 are on-chip, 0..3 are pins
	localparam logic [7:0]  SRC_INTERNAL = 8'hF0;
	// register byte offsets
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_ENABLE   = 8'h04;
	localparam logic [7:0]  OFF_PRIO     = 8'h08;
	localparam logic [7:0]  OFF_PEND     = 8'h0C;
	localparam logic [7:0]  OFF_CCR      = 8'h10;
	localparam logic [7:0]  OFF_EXR      = 8'h14;
	localparam logic [7:0]  OFF_FETCH    = 8'h18;
	localparam logic [7:0]  OFF_STATUS   = 8'h1C;
	// field positions
	localparam int          CTRL_LO_BIT  = 0;
	localparam int          CTRL_HI_BIT  = 1;
	localparam int          CCR_MASK_BIT = 7;
	localparam int          EXR_T_BIT    = 7;
	localparam int          PEND_NMI_BIT = 8;
	localparam int          FETCH_M_LSB  = 4;
	localparam int          ST_BUSY_BIT  = 8;
	localparam int          ST_NMI_BIT   = 9;
	localparam int          ST_IDX_LSB   = 12;
	localparam int          ST_VEC_LSB   = 16;
	// reset values
	localparam logic        CCR_MASK_RST = 1'b1;
	localparam logic [2:0]  LEVEL_RST    = 3'h7;
	localparam logic [2:0]  LEVEL_NMI    = 3'h7;
	// timing in states (one state is one hclk)
	localparam logic [4:0]  PRIO_EXT     = 5'h03;
	localparam logic [4:0]  PRIO_INT     = 5'h02;
	localparam logic [1:0]  PUSH_LAST_M0 = 2'h1;
	localparam logic [1:0]  PUSH_LAST_M2 = 2'h2;
	// fetch cost selector
	localparam logic [2:0]  BUS_INT      = 3'h0;
	localparam logic [2:0]  BUS_8_2S     = 3'h1;
	localparam logic [2:0]  BUS_8_3S     = 3'h2;
	localparam logic [2:0]  BUS_16_2S    = 3'h3;
	localparam logic [2:0]  BUS_16_3S    = 3'h4;
	localparam logic [4:0]  COST_INT     = 5'h01;
	localparam logic [4:0]  COST_8_2S    = 5'h04;
	localparam logic [4:0]  COST_8_3S    = 5'h06;
	localparam logic [4:0]  COST_16_2S   = 5'h02;
	localparam logic [4:0]  COST_16_3S   = 5'h03;
	// vectors
	localparam logic [7:0]  VEC_NMI      = 8'h07;
	localparam logic [7:0]  VEC_SRC_BASE = 8'h10;
	localparam logic [15:0] VEC_TBL_BASE = 16'h0000;
	localparam int          VEC_SHIFT    = 2;
endpackage

//--- core/irq_accept_ctrl.sv
// interrupt acceptance and exception entry sequencer with ahb-lite registers
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module irq_accept_ctrl (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// request sources
	input  wire logic [7:0]  src_event,
	input  wire logic [7:0]  src_clear,
	input  wire logic        nmi_event,
	input  wire logic        hw_standby,
	// cpu core
	input  wire logic        insn_end,
	input  wire logic [31:0] resume_pc,
	input  wire logic [31:0] vec_data,
	output logic             stack_wr,
	output logic [1:0]       stack_sel,
	output logic [31:0]      stack_data,
	output logic             vec_rd,
	output logic [15:0]      vec_addr,
	output logic             handler_go,
	output logic [31:0]      handler_pc,
	output logic             entry_busy
);

	typedef enum {
		ST_IDLE, ST_PRIO, ST_WAIT, ST_PREF_A, ST_INT_A,
		ST_STACK, ST_VEC, ST_INT_B, ST_PREF_B
	} state_e;

	////////////////////////////////////////////////////////////////////////
	// registers

	state_e      st_q;
	logic [4:0]  cnt_q;
	logic [1:0]  push_q;
	logic        hi_q;
	logic        lo_q;
	logic [7:0]  en_q;
	logic [23:0] prio_q;
	logic [7:0]  pend_q;
	logic        nmi_pend_q;
	logic        mask_q;
	logic        trace_q;
	logic [2:0]  level_q;
	logic [2:0]  bus_q;
	logic [2:0]  wait_m_q;
	logic        acc_nmi_q;
	logic [2:0]  acc_idx_q;
	logic [2:0]  acc_prio_q;
	logic        acc_m2_q;
	logic [31:0] ret_pc_q;
	logic        wr_q;
	logic [7:0]  waddr_q;
	logic [31:0] hrdata_q;
	logic        stack_wr_q;
	logic [1:0]  stack_sel_q;
	logic [31:0] stack_data_q;
	logic        vec_rd_q;
	logic [15:0] vec_addr_q;
	logic        go_q;
	logic [31:0] handler_pc_q;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	wire        ap_ok  = hsel & hready & htrans[1];
	wire        ap_wr  = ap_ok & hwrite;
	wire        ap_rd  = ap_ok & ~hwrite;
	wire [7:0]  ra     = haddr[7:0];
	wire        w_ctrl = wr_q & (waddr_q == irq_accept_pkg::OFF_CTRL);
	wire        w_en   = wr_q & (waddr_q == irq_accept_pkg::OFF_ENABLE);
	wire        w_prio = wr_q & (waddr_q == irq_accept_pkg::OFF_PRIO);
	wire        w_pend = wr_q & (waddr_q == irq_accept_pkg::OFF_PEND);
	wire        w_ccr  = wr_q & (waddr_q == irq_accept_pkg::OFF_CCR);
	wire        w_exr  = wr_q & (waddr_q == irq_accept_pkg::OFF_EXR);
	wire        w_fet  = wr_q & (waddr_q == irq_accept_pkg::OFF_FETCH);
	wire [7:0]  sw_clr = w_pend ? hwdata[7:0] : 8'h00;

	wire        mode2  = hi_q & ~lo_q;
	wire [31:0] r_ctrl = {30'h0, hi_q, lo_q};
	wire [31:0] r_pend = {23'h0, nmi_pend_q, pend_q};
	wire [31:0] r_ccr  = {24'h0, mask_q, 7'h00};
	wire [31:0] r_exr  = {24'h0, trace_q, 4'h0, level_q};
	wire [31:0] r_fet  = {25'h0, wait_m_q, 1'b0, bus_q};
	wire [7:0]  vec_num = acc_nmi_q ? irq_accept_pkg::VEC_NMI :
		8'(irq_accept_pkg::VEC_SRC_BASE + acc_idx_q);
	wire [31:0] r_stat = {8'h00, vec_num, 1'b0, acc_idx_q, 2'h0,
		acc_nmi_q, entry_busy, 4'h0, 4'(st_q)};
	wire [31:0] rd_mux =
		(ra == irq_accept_pkg::OFF_CTRL)   ? r_ctrl :
		(ra == irq_accept_pkg::OFF_ENABLE) ? {24'h0, en_q} :
		(ra == irq_accept_pkg::OFF_PRIO)   ? {8'h00, prio_q} :
		(ra == irq_accept_pkg::OFF_PEND)   ? r_pend :
		(ra == irq_accept_pkg::OFF_CCR)    ? r_ccr :
		(ra == irq_accept_pkg::OFF_EXR)    ? r_exr :
		(ra == irq_accept_pkg::OFF_FETCH)  ? r_fet :
		(ra == irq_accept_pkg::OFF_STATUS) ? r_stat : 32'h0;

	////////////////////////////////////////////////////////////////////////
	// request arbitration

	wire [7:0] req = pend_q & en_q;
	logic [2:0] prio_of [irq_accept_pkg::N_SRC];
	for (genvar g = 0; g < irq_accept_pkg::N_SRC; g++) begin : g_prio
		assign prio_of[g] = prio_q[g*irq_accept_pkg::PRIO_W +: irq_accept_pkg::PRIO_W];
	end

	logic       best_any;
	logic [2:0] best_idx;
	logic [2:0] best_prio;
	always_comb begin
		best_any  = 1'b0;
		best_idx  = 3'h0;
		best_prio = 3'h0;
		// lower index wins ties by scanning downward
		for (int i = irq_accept_pkg::N_SRC - 1; i >= 0; i--) begin
			if (req[i] && (!mode2 || !best_any || prio_of[i] >= best_prio)) begin
				best_any  = 1'b1;
				best_idx  = 3'(i);
				best_prio = prio_of[i];
			end
		end
	end

	wire nmi_ok   = nmi_pend_q & ~hw_standby;
	wire irq_ok   = best_any & (mode2 ? (best_prio > level_q) : ~mask_q);
	wire cand     = nmi_ok | irq_ok;
	wire cand_int = ~nmi_ok & irq_accept_pkg::SRC_INTERNAL[best_idx];

	////////////////////////////////////////////////////////////////////////
	// timing helpers

	// one fetch or stack slot in states
	wire [4:0] fcost =
		(bus_q == irq_accept_pkg::BUS_8_2S)  ? irq_accept_pkg::COST_8_2S :
		(bus_q == irq_accept_pkg::BUS_8_3S)  ? 5'(irq_accept_pkg::COST_8_3S + {wait_m_q, 1'b0}) :
		(bus_q == irq_accept_pkg::BUS_16_2S) ? irq_accept_pkg::COST_16_2S :
		(bus_q == irq_accept_pkg::BUS_16_3S) ? 5'(irq_accept_pkg::COST_16_3S + wait_m_q) :
		irq_accept_pkg::COST_INT;
	wire [4:0] fload     = 5'(fcost - 5'h01);
	wire [4:0] pload     = cand_int ? 5'(irq_accept_pkg::PRIO_INT - 5'h01) :
		5'(irq_accept_pkg::PRIO_EXT - 5'h01);
	wire [1:0] push_last = acc_m2_q ? irq_accept_pkg::PUSH_LAST_M2 :
		irq_accept_pkg::PUSH_LAST_M0;
	wire       cnt_zero  = (cnt_q == 5'h00);
	wire       stack_end = (st_q == ST_STACK) & cnt_zero & (push_q == push_last);
	wire       accept    = (st_q == ST_PRIO) & cnt_zero & cand;
	wire [15:0] vec_calc = 16'(irq_accept_pkg::VEC_TBL_BASE +
		({8'h00, vec_num} << irq_accept_pkg::VEC_SHIFT));
	wire [1:0]  next_push = 2'(push_q + 2'h1);
	wire [31:0] push_val  = (next_push == 2'h1) ? r_ccr : r_exr;

	////////////////////////////////////////////////////////////////////////
	// bus slave

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q     <= 1'b0;
			waddr_q  <= 8'h00;
			hrdata_q <= 32'h0;
		end else begin
			wr_q    <= ap_wr;
			waddr_q <= ra;
			if (ap_rd) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_q     <= 1'b0;
			lo_q     <= 1'b0;
			en_q     <= 8'h00;
			prio_q   <= 24'h0;
			bus_q    <= irq_accept_pkg::BUS_INT;
			wait_m_q <= 3'h0;
		end else begin
			if (w_ctrl) begin
				hi_q <= hwdata[irq_accept_pkg::CTRL_HI_BIT];
				lo_q <= hwdata[irq_accept_pkg::CTRL_LO_BIT];
			end
			if (w_en) begin
				en_q <= hwdata[7:0];
			end
			if (w_prio) begin
				prio_q <= hwdata[23:0];
			end
			if (w_fet) begin
				bus_q    <= hwdata[2:0];
				wait_m_q <= hwdata[irq_accept_pkg::FETCH_M_LSB +: 3];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pending flags, set wins over clear

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q     <= 8'h00;
			nmi_pend_q <= 1'b0;
		end else begin
			pend_q     <= (pend_q & ~(sw_clr | src_clear)) | (src_event & en_q);
			nmi_pend_q <= (nmi_pend_q & ~(accept & nmi_ok)) | nmi_event;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mask state, entry update wins over software

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q  <= irq_accept_pkg::CCR_MASK_RST;
			trace_q <= 1'b0;
			level_q <= irq_accept_pkg::LEVEL_RST;
		end else if (stack_end) begin
			if (acc_m2_q) begin
				trace_q <= 1'b0;
				level_q <= acc_nmi_q ? irq_accept_pkg::LEVEL_NMI : acc_prio_q;
			end else begin
				mask_q <= 1'b1;
			end
		end else begin
			if (w_ccr) begin
				mask_q <= hwdata[irq_accept_pkg::CCR_MASK_BIT];
			end
			if (w_exr) begin
				trace_q <= hwdata[irq_accept_pkg::EXR_T_BIT];
				level_q <= hwdata[2:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// exception entry sequencer

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q         <= ST_IDLE;
			cnt_q        <= 5'h00;
			push_q       <= 2'h0;
			acc_nmi_q    <= 1'b0;
			acc_idx_q    <= 3'h0;
			acc_prio_q   <= 3'h0;
			acc_m2_q     <= 1'b0;
			ret_pc_q     <= 32'h0;
			stack_wr_q   <= 1'b0;
			stack_sel_q  <= 2'h0;
			stack_data_q <= 32'h0;
			vec_rd_q     <= 1'b0;
			vec_addr_q   <= 16'h0000;
			go_q         <= 1'b0;
			handler_pc_q <= 32'h0;
		end else begin
			stack_wr_q <= 1'b0;
			vec_rd_q   <= 1'b0;
			go_q       <= 1'b0;
			if (!cnt_zero) begin
				cnt_q <= 5'(cnt_q - 5'h01);
			end
			case (st_q)
				ST_IDLE: begin
					if (cand) begin
						st_q  <= ST_PRIO;
						cnt_q <= pload;
					end
				end
				ST_PRIO: begin
					if (cnt_zero) begin
						// decision is made on the masks at the end of the window
						if (cand) begin
							acc_nmi_q  <= nmi_ok;
							acc_idx_q  <= best_idx;
							acc_prio_q <= best_prio;
							acc_m2_q   <= mode2;
							st_q       <= ST_WAIT;
						end else begin
							st_q <= ST_IDLE;
						end
					end
				end
				ST_WAIT: begin
					if (insn_end) begin
						ret_pc_q <= resume_pc;
						st_q     <= ST_PREF_A;
						cnt_q    <= fload;
					end
				end
				ST_PREF_A: begin
					if (cnt_zero) begin
						st_q <= ST_INT_A;
					end
				end
				ST_INT_A: begin
					st_q         <= ST_STACK;
					cnt_q        <= fload;
					push_q       <= 2'h0;
					stack_wr_q   <= 1'b1;
					stack_sel_q  <= 2'h0;
					stack_data_q <= ret_pc_q;
				end
				ST_STACK: begin
					if (cnt_zero) begin
						cnt_q <= fload;
						if (push_q == push_last) begin
							st_q       <= ST_VEC;
							vec_rd_q   <= 1'b1;
							vec_addr_q <= vec_calc;
						end else begin
							push_q       <= next_push;
							stack_wr_q   <= 1'b1;
							stack_sel_q  <= next_push;
							stack_data_q <= push_val;
						end
					end
				end
				ST_VEC: begin
					if (cnt_zero) begin
						handler_pc_q <= vec_data;
						st_q         <= ST_INT_B;
					end
				end
				ST_INT_B: begin
					st_q  <= ST_PREF_B;
					cnt_q <= fload;
				end
				ST_PREF_B: begin
					if (cnt_zero) begin
						go_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign hrdata     = hrdata_q;
	assign stack_wr   = stack_wr_q;
	assign stack_sel  = stack_sel_q;
	assign stack_data = stack_data_q;
	assign vec_rd     = vec_rd_q;
	assign vec_addr   = vec_addr_q;
	assign handler_go = go_q;
	assign handler_pc = handler_pc_q;
	assign entry_busy = (st_q != ST_IDLE);

endmodule
`default_nettype wire

//--- dv/irq_core_model.sv
// behavioural cpu core: instruction ends, return address, vector table
`timescale 1ns/100ps
`default_nettype none
module irq_core_model (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// bench control
	input  wire logic [4:0]  insn_len,
	// from the acceptance block
	input  wire logic        vec_rd,
	input  wire logic [15:0] vec_addr,
	input  wire logic        handler_go,
	// to the acceptance block
	output logic             insn_end,
	output var logic [31:0]  resume_pc,
	output logic [31:0]      vec_data
);
	logic [4:0]  cnt_q;
	logic [15:0] tick_q;
	logic        hold_q;
	// instruction boundary every insn_len states
	assign insn_end = (cnt_q >= insn_len - 5'h01);
	// table word valid through the vector slot, changing pattern elsewhere
	assign vec_data = (vec_rd || hold_q) ? {16'hC000, vec_addr} : {tick_q, ~tick_q};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 5'h00;
			tick_q <= 16'h0000;
			hold_q <= 1'b0;
			resume_pc <= 32'h00001000;
		end else begin
			tick_q <= tick_q + 16'h0001;
			cnt_q <= insn_end ? 5'h00 : cnt_q + 5'h01;
			if (insn_end) begin
				resume_pc <= resume_pc + 32'h00000002;
			end
			if (vec_rd) begin
				hold_q <= 1'b1;
			end else if (handler_go) begin
				hold_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/irq_accept_ctrl_checker.sv
// concurrent checks on the acceptance block ports
`timescale 1ns/100ps
`default_nettype none
module irq_accept_ctrl_checker (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// watched outputs
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic        stack_wr,
	input  wire logic [1:0]  stack_sel,
	input  wire logic        vec_rd,
	input  wire logic [15:0] vec_addr,
	input  wire logic        handler_go,
	input  wire logic        entry_busy
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire push_pc  = stack_wr && stack_sel == 2'h0;
	wire push_ccr = stack_wr && stack_sel == 2'h1;
	wire push_exr = stack_wr && stack_sel == 2'h2;
	////////////////////////////////////////////////////////////////
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	AST_QUIET: assert property ($rose(entry_busy) |-> (!stack_wr && !vec_rd && !handler_go)[*5])
		else $error("entry activity too soon after decision start");
	AST_BUSY_HOLD: assert property ($rose(entry_busy) |-> entry_busy[*2])
		else $error("priority decision shorter than two states");
	AST_PC_CCR: assert property (push_pc |-> ##[1:20] push_ccr)
		else $error("pc push not followed by ccr push");
	AST_CCR_NEXT: assert property (push_ccr |-> ##[1:20] (vec_rd || push_exr))
		else $error("ccr push not followed by exr push or vector read");
	AST_VEC_GO: assert property (vec_rd |-> ##[3:60] handler_go)
		else $error("handler not started after vector read");
	AST_VEC_NUM: assert property (vec_rd |-> (vec_addr == 16'h001C ||
		(vec_addr >= 16'h0040 && vec_addr <= 16'h005C && vec_addr[1:0] == 2'h0)))
		else $error("vector address outside table");
	AST_GO_IDLE: assert property (handler_go |-> !entry_busy && $past(entry_busy))
		else $error("handler start without finishing entry");
	AST_STACK_BUSY: assert property (stack_wr |-> entry_busy)
		else $error("stack push outside entry");
	////////////////////////////////////////////////////////////////
	cover property (push_exr);
	cover property (vec_rd && vec_addr == 16'h001C);
	cover property ($rose(entry_busy));
endmodule
bind irq_accept_ctrl irq_accept_ctrl_checker irq_accept_ctrl_checker_i (.hclk, .hresetn,
	.hreadyout, .hresp, .stack_wr, .stack_sel, .vec_rd, .vec_addr, .handler_go, .entry_busy);
`default_nettype wire

//--- dv/dual_mode_interrupt_acceptance_tb.sv
// self-checking bench for the interrupt acceptance block
`timescale 1ns/100ps
`default_nettype none
module dual_mode_interrupt_acceptance_tb;
	logic             hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, nmi_event = 1'b0;
	logic             hw_standby = 1'b0;
	logic [1:0]       htrans = 2'h0;
	logic [7:0]       src_event = 8'h00, src_clear = 8'h00;
	logic [4:0]       insn_len = 5'h01;
	logic [31:0]      haddr = 32'h0, hwdata = 32'h0, rv;
	logic [31:0]      pushed [3];
	wire logic        hreadyout, hresp, insn_end, stack_wr, vec_rd, handler_go, entry_busy;
	wire logic [1:0]  stack_sel;
	wire logic [15:0] vec_addr;
	wire logic [31:0] hrdata, resume_pc, vec_data, stack_data, handler_pc;
	int               bad_count = 0, compares = 0, pushes = 0;
	always #50 hclk = ~hclk;
	always @(posedge hclk) if (stack_wr) begin
		pushed[stack_sel] <= stack_data;
		pushes <= pushes + 1;
	end
	irq_accept_ctrl irq_accept_ctrl_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .src_event,
		.src_clear, .nmi_event, .hw_standby, .insn_end, .resume_pc, .vec_data, .stack_wr,
		.stack_sel, .stack_data, .vec_rd, .vec_addr, .handler_go, .handler_pc, .entry_busy);
	irq_core_model irq_core_model_i (.hclk, .hresetn, .insn_len, .vec_rd, .vec_addr,
		.handler_go, .insn_end, .resume_pc, .vec_data);
	////////////////////////////////////////////////////////////////
	task close_out;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rdy;
		int k;
		for (k = 0; k < 50; k++) begin
			@(posedge hclk);
			if (hready_ok()) break;
		end
		if (k == 50) begin
			bad_count++;
			close_out;
		end
	endtask
	function automatic bit hready_ok();
		return hreadyout === 1'b1;
	endfunction
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= 1'b1;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= 1'b0;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		rdy;
		rv = hrdata;
		chk(nm, e, rv);
	endtask
	task fire(input logic [7:0] s, input logic n);
		@(posedge hclk);
		src_event <= s;
		nmi_event <= n;
		@(posedge hclk);
		src_event <= 8'h00;
		nmi_event <= 1'b0;
	endtask
	task clr(input logic [7:0] c, input logic [7:0] s);
		@(posedge hclk);
		src_clear <= c;
		src_event <= s;
		@(posedge hclk);
		src_clear <= 8'h00;
		src_event <= 8'h00;
	endtask
	task quiet;
		repeat (10) begin
			@(posedge hclk);
			#1 chk("busy", 32'h0, {31'h0, entry_busy});
		end
	endtask
	function automatic int lat(input int pr, input int cost, input int n);
		return pr + 4 + (n + 3) * cost;
	endfunction
	task go(input logic [15:0] va, input int en, input int np);
		int n;
		int p0;
		p0 = pushes;
		for (n = 1; n <= 300; n++) begin
			@(posedge hclk);
			#1;
			if (handler_go === 1'b1) break;
		end
		if (n > 300) begin
			bad_count++;
			close_out;
		end
		if (en > 0) chk("latency", en, n);
		chk("vector", {16'h0, va}, {16'h0, vec_addr});
		chk("handler", {16'hC000, va}, handler_pc);
		chk("pushes", np, pushes - p0);
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		rchk("ctrl", 8'h00, 32'h0);
		rchk("ccr", 8'h10, 32'h80);
		rchk("exr", 8'h14, 32'h07);
		rchk("pend", 8'h0C, 32'h0);
		rchk("unmapped", 8'h40, 32'h0);
	endtask
	task t_enable;
		fire(8'h02, 1'b0);
		rchk("pend", 8'h0C, 32'h0);
		wr(8'h04, 32'hFF);
		fire(8'h0A, 1'b0);
		rchk("pend", 8'h0C, 32'h0A);
		clr(8'h0A, 8'h08);
		rchk("pend", 8'h0C, 32'h08);
		fire(8'h02, 1'b0);
	endtask
	task t_mask0;
		quiet;
		@(posedge hclk);
		hw_standby <= 1'b1;
		insn_len <= 5'h13;
		fire(8'h00, 1'b1);
		quiet;
		@(posedge hclk);
		hw_standby <= 1'b0;
		go(16'h001C, 0, 2);
		chk("pc push", resume_pc - 32'h00000002, pushed[0]);
		chk("ccr push", 32'h80, {24'h0, pushed[1][7:0]} & 32'h80);
		rchk("pend", 8'h0C, 32'h0A);
		insn_len <= 5'h01;
	endtask
	task t_mode0;
		wr(8'h0C, 32'hFF);
		wr(8'h10, 32'h0);
		fire(8'h0A, 1'b0);
		go(16'h0044, lat(3, 1, 2), 2);
		chk("ccr push", 32'h0, {24'h0, pushed[1][7:0]} & 32'h80);
		rchk("ccr", 8'h10, 32'h80);
		rchk("pend", 8'h0C, 32'h0A);
		wr(8'h0C, 32'hFF);
		wr(8'h10, 32'h0);
		fire(8'h10, 1'b0);
		go(16'h0050, lat(2, 1, 2), 2);
		rchk("status", 8'h1C, 32'h00144000);
	endtask
	task t_mode2;
		wr(8'h0C, 32'hFF);
		wr(8'h00, 32'h2);
		wr(8'h14, 32'h83);
		wr(8'h08, 32'h00028143);
		fire(8'h01, 1'b0);
		quiet;
		fire(8'h24, 1'b0);
		go(16'h0048, lat(3, 1, 3), 3);
		chk("exr push", 32'h83, {24'h0, pushed[2][7:0]});
		rchk("exr", 8'h14, 32'h05);
		wr(8'h0C, 32'hFF);
		wr(8'h18, 32'h1);
		wr(8'h14, 32'h0);
		fire(8'h20, 1'b0);
		go(16'h0054, lat(2, 4, 3), 3);
		rchk("exr", 8'h14, 32'h05);
		fire(8'h00, 1'b1);
		go(16'h001C, lat(3, 4, 3), 3);
		rchk("exr", 8'h14, 32'h07);
		wr(8'h18, 32'h12);
		fire(8'h00, 1'b1);
		go(16'h001C, lat(3, 8, 3), 3);
		wr(8'h18, 32'h3);
		fire(8'h00, 1'b1);
		go(16'h001C, lat(3, 2, 3), 3);
		wr(8'h18, 32'h24);
		fire(8'h00, 1'b1);
		go(16'h001C, lat(3, 5, 3), 3);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_enable;
		t_mask0;
		t_mode0;
		t_mode2;
		close_out;
	end
endmodule
`default_nettype wire
